// ### design/dhs_sequencer.sv
// Dog homing sequencer: rear-end, count-type front-end and dog cradle.
// Assumes the axis position input counts in the homing direction sign,
// and dog and Z-phase arrive asynchronously from pins.
//
// Functional notes
// - Method code 5 runs dog rear-end reference homing.
// - Method code 6 runs count-type dog front-end reference homing.
// - Home return speed until dog found, then creep speed.
// - Direction and dog polarity come from their parameters.
// - After dog rear end, travel after-dog distance before any shift.
// - Final home offset by shift distance after the after-dog travel.
// - Count type decelerates at dog front end, no Z-phase dependence.
// - Point table entry 1 accel/decel constants used for all moves.
// - On completion current position loads home position data.
// - Dog cradle home is first Z-phase after dog front end.
// - Rear-end home is after-dog plus shift past the dog rear end.
// - Home complete output asserts once home is established.
`timescale 1ns/1ps
module dhs_sequencer #(
  parameter int PT_SEL_W = dhs_pkg::PT_SEL_W
) (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        arst_n_i,
  // Master remote inputs
  input  wire logic                        auto_manual_select_in_i,
  input  wire logic [PT_SEL_W-1:0]         point_table_select_i,
  input  wire logic                        pos_speed_source_select_in_i,
  input  wire logic                        two_station_i,
  input  wire logic                        start_i,
  // Parameters
  input  wire logic [3:0]                  homing_method_param_i,
  input  wire logic                        homing_direction_param_i,
  input  wire logic                        dog_polarity_param_i,
  input  wire logic [dhs_pkg::SPEED_W-1:0] homing_speed_param_i,
  input  wire logic [dhs_pkg::SPEED_W-1:0] creep_speed_param_i,
  input  wire logic [dhs_pkg::POS_W-1:0]   home_shift_distance_param_i,
  input  wire logic [dhs_pkg::POS_W-1:0]   after_dog_distance_param_i,
  input  wire logic [dhs_pkg::POS_W-1:0]   home_position_data_param_i,
  input  wire logic [dhs_pkg::SPEED_W-1:0] pt1_accel_step_i,
  input  wire logic [dhs_pkg::SPEED_W-1:0] pt1_decel_step_i,
  // Axis side
  input  wire logic                        dog_pin_i,
  input  wire logic                        zphase_pin_i,
  input  wire logic [dhs_pkg::POS_W-1:0]   axis_travel_i,
  // Outputs
  output logic      [dhs_pkg::SPEED_W-1:0] speed_cmd_o,
  output logic                             direction_o,
  output logic                             moving_o,
  output logic                             home_complete_out_o,
  output logic                             mode_error_o,
  output logic      [dhs_pkg::POS_W-1:0]   current_position_o
);
  import dhs_pkg::*;

  // Elaboration checks: the table field needs a bit and the divider a span
  if (PT_SEL_W < 1) begin : g_bad_pt_sel_w
    $error("PT_SEL_W must be at least 1");
  end
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  // ==========================================================================
  // Helpers

  // Countdown length; the sum is cut to the position width on purpose, a
  // pair of distances that overflows it is a setup error of the user
  function automatic logic [POS_W-1:0] dist_sum(
    input logic [POS_W-1:0] first_dist,
    input logic [POS_W-1:0] second_dist
  );
    dist_sum = POS_W'(first_dist + second_dist);
  endfunction

  // Idle and done are the only states that accept a start
  function automatic logic at_rest(input dhs_state_e st);
    at_rest = (st == ST_IDLE) || (st == ST_DONE);
  endfunction

  // ==========================================================================
  // Input synchronisers
  logic [1:0] dog_sync_reg;
  logic [1:0] z_sync_reg;
  logic       dog_act_reg;
  logic       z_prev_reg;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dog_sync_reg <= 2'h0;
      z_sync_reg   <= 2'h0;
    end else begin
      dog_sync_reg <= {dog_sync_reg[0], dog_pin_i};
      z_sync_reg   <= {z_sync_reg[0], zphase_pin_i};
    end
  end

  // Polarity is applied before any edge detection
  logic dog_act;
  assign dog_act = dog_sync_reg[1] ^ dog_polarity_param_i;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dog_act_reg <= 1'b0;
      z_prev_reg  <= 1'b0;
    end else begin
      dog_act_reg <= dog_act;
      z_prev_reg  <= z_sync_reg[1];
    end
  end

  // Edge detectors run every cycle; each state reads only the edge it needs
  logic dog_front;
  logic dog_rear;
  logic z_rise;
  assign dog_front = dog_act & ~dog_act_reg;
  assign dog_rear  = ~dog_act & dog_act_reg;
  assign z_rise    = z_sync_reg[1] & ~z_prev_reg;

  // ==========================================================================
  // Mode qualification: master must select manual mode with table bits off
  logic manual_ok;
  logic source_ok;
  assign manual_ok = auto_manual_select_in_i
                     && (point_table_select_i == '0);
  // Two-station remote setting needs the source select on
  assign source_ok = !two_station_i || pos_speed_source_select_in_i;

  logic method_ok;
  assign method_ok = (homing_method_param_i == METHOD_DOG_REAR)
                  || (homing_method_param_i == METHOD_CNT_FRONT)
                  || (homing_method_param_i == METHOD_CRADLE);

  // ==========================================================================
  // Speed tick divider
  localparam int TICK_W = $clog2(TICK_CYC);
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick;
  assign tick = (tick_cnt_reg == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : TICK_W'(tick_cnt_reg + 1'b1);
    end
  end

  // ==========================================================================
  // Sequencer
  dhs_state_e          state_reg;
  logic [3:0]          method_reg;
  logic [POS_W-1:0]    mark_reg;   // Travel where the countdown starts
  logic [POS_W-1:0]    dist_reg;   // Distance to cover from the mark
  logic [POS_W-1:0]    travelled;
  logic                reached;
  logic                start_go;
  logic [SPEED_W-1:0]  speed_now;  // Ramp output, read by the stop test

  // Distance since the marked point, wrap-safe
  assign travelled = POS_W'(axis_travel_i - mark_reg);
  assign reached   = (travelled >= dist_reg);

  // A start is taken only with the mode bits and the method all valid
  assign start_go = start_i && manual_ok && source_ok && method_ok;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg  <= ST_IDLE;
      method_reg <= 4'h0;
      mark_reg   <= '0;
      dist_reg   <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_go) begin
            method_reg <= homing_method_param_i;
            state_reg  <= ST_FAST;
          end
        end
        // Fast approach until the dog front end
        ST_FAST: begin
          if (dog_front) begin
            if (method_reg == METHOD_CNT_FRONT) begin
              // Countdown starts at the front end, no Z-phase
              mark_reg  <= axis_travel_i;
              dist_reg  <= dist_sum(after_dog_distance_param_i,
                                    home_shift_distance_param_i);
              state_reg <= ST_TRAV;
            end else begin
              state_reg <= (method_reg == METHOD_CRADLE) ? ST_ONDOG
                                                         : ST_CREEP;
            end
          end
        end
        // Rear-end method: creep across the dog
        ST_CREEP: begin
          if (dog_rear) begin
            mark_reg  <= axis_travel_i;
            dist_reg  <= dist_sum(after_dog_distance_param_i,
                                  home_shift_distance_param_i);
            state_reg <= ST_TRAV;
          end
        end
        // Cradle: first Z-phase after the front end is the home
        ST_ONDOG: begin
          if (z_rise) begin
            mark_reg  <= axis_travel_i;
            dist_reg  <= home_shift_distance_param_i;
            state_reg <= ST_TRAV;
          end
        end
        // Count down from the mark; the stop ramp adds some overshoot
        ST_TRAV: begin
          if (reached) begin
            state_reg <= ST_STOP;
          end
        end
        // Wait for the ramp to bring the axis to rest
        ST_STOP: begin
          if (speed_now == '0) begin
            state_reg <= ST_DONE;
          end
        end
        // A new return may start from done; the old home stands until then
        ST_DONE: begin
          if (start_go) begin
            method_reg <= homing_method_param_i;
            state_reg  <= ST_FAST;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Speed target and ramp (table entry 1 steps only)
  logic [SPEED_W-1:0] target;
  logic [SPEED_W-1:0] step;

  always_comb begin
    target = '0;
    case (state_reg)
      ST_FAST:  target = homing_speed_param_i;
      ST_CREEP: target = creep_speed_param_i;
      ST_ONDOG: target = creep_speed_param_i;
      // Count type keeps decelerating toward creep from the front end
      ST_TRAV:  target = creep_speed_param_i;
      default:  target = '0;
    endcase
  end

  // Accelerating or decelerating picks the matching constant
  assign step = (target > speed_now) ? pt1_accel_step_i
                                     : pt1_decel_step_i;

  dhs_ramp u_ramp (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (tick),
    .target_i  (target),
    .step_i    (step),
    .speed_o   (speed_now)
  );

  // ==========================================================================
  // Outputs, all registered
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      speed_cmd_o <= '0;
      direction_o <= 1'b0;
      moving_o    <= 1'b0;
    end else begin
      speed_cmd_o <= speed_now;
      direction_o <= homing_direction_param_i;
      moving_o    <= !at_rest(state_reg);
    end
  end

  // Completion flag drops when a new return starts
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      home_complete_out_o <= 1'b0;
      current_position_o  <= '0;
    end else if (state_reg == ST_STOP && speed_now == '0) begin
      home_complete_out_o <= 1'b1;
      current_position_o  <= home_position_data_param_i;
    end else if (state_reg == ST_FAST) begin
      home_complete_out_o <= 1'b0;
    end
  end

  // Start refused for a bad mode selection
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_error_o <= 1'b0;
    end else if (start_i && at_rest(state_reg)) begin
      mode_error_o <= !(manual_ok && source_ok && method_ok);
    end
  end

endmodule // dhs_sequencer

// ### design/dhs_pkg.sv
// Constants shared by the dog homing sequencer and its profile generator.
// Assumes a single 200 MHz clock domain and parameters held stable
// while a home return is in progress.
package dhs_pkg;

  // ==========================================================================
  // Method codes (lowest decimal digit of the homing method parameter)
  localparam logic [3:0] METHOD_DOG_REAR  = 4'h5;
  localparam logic [3:0] METHOD_CNT_FRONT = 4'h6;
  localparam logic [3:0] METHOD_CRADLE    = 4'h7;

  // ==========================================================================
  // Widths and timing
  localparam int SPEED_W  = 16;
  localparam int POS_W    = 32;
  localparam int TIME_W   = 16;
  localparam int CLK_MHZ  = 200;
  // Speed update tick, in microseconds, and its count in cycles
  localparam int TICK_US  = 1;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int PT_SEL_W = 8;

  // ==========================================================================
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_FAST  = 7'h02,
    ST_CREEP = 7'h04,
    ST_ONDOG = 7'h08,
    ST_TRAV  = 7'h10,
    ST_STOP  = 7'h20,
    ST_DONE  = 7'h40
  } dhs_state_e;

endpackage : dhs_pkg

// ### design/dhs_ramp.sv
// Speed ramp generator: slews the commanded speed toward a target.
// Assumes a one-cycle tick enable and a step per tick from the caller.
`timescale 1ns/1ps
module dhs_ramp (
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          arst_n_i,
  // Control
  input  wire logic                          tick_i,
  input  wire logic [dhs_pkg::SPEED_W-1:0]   target_i,
  input  wire logic [dhs_pkg::SPEED_W-1:0]   step_i,
  // Result
  output logic      [dhs_pkg::SPEED_W-1:0]   speed_o
);
  import dhs_pkg::*;

  logic [SPEED_W-1:0] speed_reg;
  assign speed_o = speed_reg;

  // ==========================================================================
  // Slew one step per tick, never overshooting the target
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      speed_reg <= '0;
    end else if (tick_i) begin
      if (speed_reg < target_i) begin
        speed_reg <= (target_i - speed_reg > step_i)
                     ? SPEED_W'(speed_reg + step_i) : target_i;
      end else if (speed_reg > target_i) begin
        speed_reg <= (speed_reg - target_i > step_i)
                     ? SPEED_W'(speed_reg - step_i) : target_i;
      end
    end
  end

endmodule // dhs_ramp

// ### test/dhs_checker.sv
// Port checker for the dog homing sequencer.
// Assumes start arrives as a one-cycle pulse, parameters still per run.
`timescale 1ns/1ps
module dhs_checker #(
  parameter int PT_SEL_W = dhs_pkg::PT_SEL_W
) (
  // Clock and reset
  input wire logic                        sys_clk_i,
  input wire logic                        arst_n_i,
  // Master and parameters
  input wire logic                        auto_manual_select_in_i,
  input wire logic [PT_SEL_W-1:0]         point_table_select_i,
  input wire logic                        pos_speed_source_select_in_i,
  input wire logic                        two_station_i,
  input wire logic                        start_i,
  input wire logic [3:0]                  homing_method_param_i,
  input wire logic                        homing_direction_param_i,
  input wire logic [dhs_pkg::SPEED_W-1:0] homing_speed_param_i,
  input wire logic [dhs_pkg::POS_W-1:0]   home_position_data_param_i,
  // Outputs
  input wire logic [dhs_pkg::SPEED_W-1:0] speed_cmd_o,
  input wire logic                        direction_o,
  input wire logic                        moving_o,
  input wire logic                        home_complete_out_o,
  input wire logic                        mode_error_o,
  input wire logic [dhs_pkg::POS_W-1:0]   current_position_o
);
  import dhs_pkg::*;
  // ====================
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic start_ok;
  // Manual mode, no table bits, source set when two stations, known method
  assign start_ok = auto_manual_select_in_i && (point_table_select_i == '0)
    && (!two_station_i || pos_speed_source_select_in_i)
    && (homing_method_param_i inside {METHOD_DOG_REAR, METHOD_CNT_FRONT,
                                      METHOD_CRADLE});
  a_start_refused: assert property (
    $rose(start_i) && !moving_o && !start_ok |-> ##[1:2] mode_error_o)
    else $error("unqualified start not flagged");
  a_start_taken: assert property (
    $rose(start_i) && !moving_o && start_ok
      |=> !mode_error_o ##[1:2] moving_o)
    else $error("qualified start did not move");
  a_done_position: assert property (
    $rose(home_complete_out_o)
      |-> current_position_o == home_position_data_param_i)
    else $error("position not loaded at completion");
  a_done_still: assert property (
    $rose(home_complete_out_o) |-> speed_cmd_o == '0 ##[0:2] !moving_o)
    else $error("completion while axis still moving");
  a_done_holds: assert property (
    $fell(home_complete_out_o) |-> $past(start_i) || $past(start_i, 2))
    else $error("completion dropped without start");
  a_error_holds: assert property (
    $fell(mode_error_o) |-> $past(start_i) || $past(start_i, 2))
    else $error("mode error dropped without start");
  a_dir_follow: assert property (
    moving_o |-> direction_o == homing_direction_param_i)
    else $error("direction differs from parameter");
  a_speed_cap: assert property (
    speed_cmd_o <= homing_speed_param_i)
    else $error("speed above home return speed");
  // Main scenarios reached
  c_done: cover property ($rose(home_complete_out_o));
  c_refused: cover property ($rose(mode_error_o));
  c_moving: cover property ($rose(moving_o));
endmodule // dhs_checker

bind dhs_sequencer dhs_checker #(
  .PT_SEL_W (PT_SEL_W)
) u_dhs_checker (
  .sys_clk_i                    (sys_clk_i),
  .arst_n_i                     (arst_n_i),
  .auto_manual_select_in_i      (auto_manual_select_in_i),
  .point_table_select_i         (point_table_select_i),
  .pos_speed_source_select_in_i (pos_speed_source_select_in_i),
  .two_station_i                (two_station_i),
  .start_i                      (start_i),
  .homing_method_param_i        (homing_method_param_i),
  .homing_direction_param_i     (homing_direction_param_i),
  .homing_speed_param_i         (homing_speed_param_i),
  .home_position_data_param_i   (home_position_data_param_i),
  .speed_cmd_o                  (speed_cmd_o),
  .direction_o                  (direction_o),
  .moving_o                     (moving_o),
  .home_complete_out_o          (home_complete_out_o),
  .mode_error_o                 (mode_error_o),
  .current_position_o           (current_position_o)
);

// ### test/dhs_master_model.sv
// Fieldbus master model: drives the remote input bits of the sequencer.
// Assumes the testbench calls request from its own thread.
`timescale 1ns/1ps
module dhs_master_model (
  // Clock
  input  wire logic                        sys_clk_i,
  // Remote input bits
  output logic                             auto_manual_select_in_o,
  output logic [dhs_pkg::PT_SEL_W-1:0]     point_table_select_o,
  output logic                             pos_speed_source_select_in_o,
  output logic                             two_station_o,
  output logic                             start_o
);
  import dhs_pkg::*;
  // ====================
  // Quiet master until asked
  initial begin
    auto_manual_select_in_o = 1'b0;
    point_table_select_o = '0;
    pos_speed_source_select_in_o = 1'b0;
    two_station_o = 1'b0;
    start_o = 1'b0;
  end
  // Mode bits first, start only after the link delay has passed
  task automatic request(input logic am, input logic [PT_SEL_W-1:0] pt,
                         input logic two, input logic src);
    @(posedge sys_clk_i);
    auto_manual_select_in_o <= am;
    point_table_select_o <= pt;
    two_station_o <= two;
    pos_speed_source_select_in_o <= src;
    repeat (4) @(posedge sys_clk_i);
    start_o <= 1'b1;
    @(posedge sys_clk_i);
    start_o <= 1'b0;
  endtask
endmodule // dhs_master_model

// ### test/testbench.sv
// Testbench for the dog homing sequencer with a simple axis model.
// Assumes one 200 MHz clock; travel grows by the speed each cycle.
`timescale 1ns/1ps
module testbench;
  import dhs_pkg::*;
  localparam logic [31:0] DOG_A = 32'h0000_03E8; // Dog spans 1000..4999
  localparam logic [31:0] DOG_B = 32'h0000_1388;
  localparam logic [31:0] HOME = 32'h0000_1234;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] method = 4'h5;
  logic dir = 1'b0, pol = 1'b0, pos_clr = 1'b1;
  logic [15:0] hs = 16'h0004, cs = 16'h0001, pre_max, dog_max;
  logic [31:0] ad = 32'h0000_01F4, sh = 32'h0000_012C, hd = HOME, pos;
  logic am, src, two, start, dog, zp, diro, mov, done, merr;
  logic [7:0] pt;
  logic [15:0] spd;
  logic [31:0] cur;
  int error_cnt = 0, num_checks = 0;
  // ====================
  // Clock and axis; dog and Z-phase follow the travel
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  assign dog = ((pos >= DOG_A) && (pos < DOG_B)) ^ pol;
  assign zp = (pos >= 32'h1F4 && pos < 32'h204)
           || (pos >= 32'h5DC && pos < 32'h5EC);
  always @(posedge sys_clk_i) begin
    if (pos_clr) begin
      pos <= '0;
      pre_max <= '0;
      dog_max <= '0;
    end else begin
      pos <= pos + {16'h0000, spd};
      if (pos < DOG_A && spd > pre_max) pre_max <= spd;
      // Skip the decel span after the dog edge
      if (pos >= 32'h7D0 && pos < 32'h1324 && spd > dog_max) dog_max <= spd;
    end
  end
  dhs_master_model u_dhs_master_model (
    .sys_clk_i(sys_clk_i), .auto_manual_select_in_o(am),
    .point_table_select_o(pt), .pos_speed_source_select_in_o(src),
    .two_station_o(two), .start_o(start));
  dhs_sequencer u_dhs_sequencer (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .auto_manual_select_in_i(am), .point_table_select_i(pt),
    .pos_speed_source_select_in_i(src), .two_station_i(two),
    .start_i(start), .homing_method_param_i(method),
    .homing_direction_param_i(dir), .dog_polarity_param_i(pol),
    .homing_speed_param_i(hs), .creep_speed_param_i(cs),
    .home_shift_distance_param_i(sh), .after_dog_distance_param_i(ad),
    .home_position_data_param_i(hd), .pt1_accel_step_i(hs),
    .pt1_decel_step_i(hs), .dog_pin_i(dog), .zphase_pin_i(zp),
    .axis_travel_i(pos), .speed_cmd_o(spd), .direction_o(diro),
    .moving_o(mov), .home_complete_out_o(done), .mode_error_o(merr),
    .current_position_o(cur));
  // ====================
  // Range compare; an unknown never lands inside the range
  task automatic chk(input string nm, input logic [31:0] lo, hi, got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h..%0h seen %0h", nm, lo, hi, got);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Start a qualified return from travel zero; wait bounded for completion
  task automatic do_home(input logic [3:0] m, input logic p, d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    method <= m;
    pol <= p;
    dir <= d;
    pos_clr <= 1'b1;
    @(posedge sys_clk_i);
    pos_clr <= 1'b0;
    u_dhs_master_model.request(1'b1, 8'h00, 1'b1, 1'b1);
    repeat (3) @(posedge sys_clk_i);
    while (done !== 1'b1 && n < 40000) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 40000) begin
      error_cnt++;
      $display("CHECK FAILED completion expected 1 seen timeout");
      tally_and_finish();
    end
    repeat (3) @(posedge sys_clk_i);
  endtask
  // No manual, a table bit, source off on two stations, unknown method
  task automatic t_refuse;
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      method <= (i == 3) ? 4'h4 : 4'h5;
      u_dhs_master_model.request(i != 0, (i == 1) ? 8'h80 : 8'h00,
                                 i == 2, 1'b0);
      repeat (3) @(posedge sys_clk_i);
      chk("mode error", 32'h1, 32'h1, {31'h0, merr});
      chk("moving", 32'h0, 32'h0, {31'h0, mov});
    end
  endtask
  task automatic t_rear;
    do_home(4'h5, 1'b0, 1'b0);
    chk("rear home", 32'h16A8, 32'h1A90, pos);
    chk("position", HOME, HOME, cur);
    chk("complete", 32'h1, 32'h1, {31'h0, done});
    chk("fast speed", 32'(hs), 32'(hs), 32'(pre_max));
    chk("creep speed", 32'h0, {16'h0, cs}, {16'h0, dog_max});
    chk("direction", 32'h0, 32'h0, {31'h0, diro});
  endtask
  // Inverted dog pin and reverse direction
  task automatic t_count;
    do_home(4'h6, 1'b1, 1'b1);
    chk("count home", 32'h0708, 32'h0AF0, pos);
    chk("direction", 32'h1, 32'h1, {31'h0, diro});
    chk("position", HOME, HOME, cur);
  endtask
  // A Z pulse before the dog must be passed over
  task automatic t_cradle;
    do_home(4'h7, 1'b0, 1'b0);
    chk("cradle home", 32'h0708, 32'h0AF0, pos);
    chk("complete", 32'h1, 32'h1, {31'h0, done});
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    t_refuse();
    t_rear();
    t_count();
    t_cradle();
    tally_and_finish();
  end
endmodule // testbench
